// *** src/pfio_consts.vh ***
// constants for the panel fieldbus i/o image block
// assumes one 250 MHz clock; included by bare name
`ifndef PFIO_CONSTS_VH
`define PFIO_CONSTS_VH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define PFIO_CLK_MHZ        250
`define PFIO_FLASH_MS       250
`define PFIO_FLASH_CYC      (`PFIO_FLASH_MS * 1000 * `PFIO_CLK_MHZ)
// ----------------------------------------------------------------
// config switch bank fields (bit 0 is position 1)
// ----------------------------------------------------------------
`define PFIO_SW_ADDR_LSB    0
`define PFIO_SW_ADDR_MSB    6
`define PFIO_SW_HWVAR_BIT   7
`define PFIO_SW_CONN_LO     8
`define PFIO_SW_CONN_HI     9
// ----------------------------------------------------------------
// image sizes and offsets in bytes
// ----------------------------------------------------------------
`define PFIO_STD_BYTES      8
`define PFIO_IN_BYTES       17
`define PFIO_OUT_BYTES      10
`define PFIO_IN_HW1         8
`define PFIO_IN_HW2         10
`define PFIO_IN_DIRECT      12
`define PFIO_IN_CUST        14
`define PFIO_IN_ROT1        15
`define PFIO_IN_ROT2        16
`define PFIO_OUT_RSVD       8
`define PFIO_OUT_CLED       9
`define PFIO_HW_ZERO        16'h0000
`define PFIO_CUST_KEYS      7
// ----------------------------------------------------------------
// version fields shown in version display
// ----------------------------------------------------------------
`define PFIO_VER_MAJ        4'h1
`define PFIO_VER_MIN        4'h2
`define PFIO_VER_PATCH      4'h0
`endif

// *** src/pfio_hw_counter.v ***
// one handwheel position counter with 16-bit wrap
// assumes step/direction pulses already synchronised to ref_clk_in
`timescale 1ns/100ps
`include "pfio_consts.vh"
module pfio_hw_counter (
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  input  wire        step_in,
  input  wire        dir_up_in,
  input  wire        present_in,
  output wire [15:0] count_out
);
  reg [15:0] count_q;
  // ----------------------------------------------------------------
  // counter, starts at zero
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= `PFIO_HW_ZERO;
    end else if (!present_in) begin
      count_q <= `PFIO_HW_ZERO; // absent wheel held at zero
    end else if (step_in) begin
      if (dir_up_in) begin
        count_q <= count_q + 16'h0001;
      end else begin
        count_q <= count_q - 16'h0001;
      end
    end
  end
  assign count_out = count_q;
endmodule // pfio_hw_counter

// *** src/pfio_image_buf.v ***
// small byte memory holding the received output image
// assumes writes and reads on the same clock; read data registered
`timescale 1ns/100ps
`include "pfio_consts.vh"
module pfio_image_buf #(
  parameter DEPTH = `PFIO_OUT_BYTES,
  parameter AW    = 4
) (
  input  wire          ref_clk_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [7:0]    wr_data_in,
  input  wire [AW-1:0] rd_addr_in,
  output wire [7:0]    rd_data_out
);
  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] rd_q;
  // ----------------------------------------------------------------
  // write port and registered read port
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_q <= mem[rd_addr_in];
  end
  assign rd_data_out = rd_q;
endmodule // pfio_image_buf

// *** src/pfio_panel.v ***
// panel logic: switch bank decode, front leds, cyclic i/o image
// assumes a fieldbus engine on ref_clk_in that streams output bytes
// in and shifts input bytes out, one per strobe, lowest byte first
`timescale 1ns/100ps
`include "pfio_consts.vh"
module pfio_panel #(
  parameter FLASH_CYC = `PFIO_FLASH_CYC,
  parameter LED_GRP   = 8
) (
  input  wire                  ref_clk_in,
  input  wire                  rst_n_in,
  input  wire [9:0]            config_switch_bank_in,
  input  wire [63:0]           std_keys_in,
  input  wire                  key_feed_stop_in,
  input  wire                  key_feed_enable_in,
  input  wire [1:0]            hw_step_in,
  input  wire [1:0]            hw_dir_up_in,
  input  wire [1:0]            hw_present_in,
  input  wire [15:0]           direct_keys_in,
  input  wire [6:0]            cust_keys_in,
  input  wire [7:0]            rotary1_in,
  input  wire [7:0]            rotary2_in,
  input  wire                  cyclic_up_in,
  input  wire                  xchg_start_in,
  input  wire                  out_strobe_in,
  input  wire [7:0]            out_byte_in,
  input  wire                  in_strobe_in,
  output wire [7:0]            in_byte_out,
  output wire [6:0]            slave_addr_out,
  output wire                  conn_fieldbus_out,
  output wire                  conn_prog_port_out,
  output wire                  hw_standard_out,
  output wire [63:0]           std_leds_out,
  output wire [7:0]            cust_leds_out,
  output wire [3*LED_GRP-1:0]  ver_leds_out,
  output wire                  ver_mode_out
);
  // ----------------------------------------------------------------
  // input synchronisers (pins from outside the clock domain)
  // ----------------------------------------------------------------
  localparam NSYNC = 10 + 64 + 2 + 2 + 2 + 2 + 16 + 7 + 8 + 8;
  wire [NSYNC-1:0] raw_w = {config_switch_bank_in, std_keys_in,
    key_feed_stop_in, key_feed_enable_in, hw_step_in, hw_dir_up_in,
    hw_present_in, direct_keys_in, cust_keys_in, rotary1_in, rotary2_in};
  reg  [NSYNC-1:0] s1_q;
  reg  [NSYNC-1:0] s2_q;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= {NSYNC{1'b0}};
      s2_q <= {NSYNC{1'b0}};
    end else begin
      s1_q <= raw_w;
      s2_q <= s1_q;
    end
  end
  wire [9:0]  sw_w     = s2_q[NSYNC-1 -: 10];
  wire [63:0] keys_w   = s2_q[NSYNC-11 -: 64];
  wire        fstop_w  = s2_q[NSYNC-75];
  wire        fen_w    = s2_q[NSYNC-76];
  wire [1:0]  step_w   = s2_q[NSYNC-77 -: 2];
  wire [1:0]  dirup_w  = s2_q[NSYNC-79 -: 2];
  wire [1:0]  pres_w   = s2_q[NSYNC-81 -: 2];
  wire [15:0] direct_w = s2_q[NSYNC-83 -: 16];
  wire [6:0]  cust_w   = s2_q[NSYNC-99 -: 7];
  wire [7:0]  rot1_w   = s2_q[15:8];
  wire [7:0]  rot2_w   = s2_q[7:0];

  // ----------------------------------------------------------------
  // switch bank capture, once after reset release
  // ----------------------------------------------------------------
  // sync chain needs two edges to fill; capture on the third
  reg [1:0] cap_cnt_q;
  reg       cap_done_q;
  reg [9:0] sw_q;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_cnt_q  <= 2'h0;
      cap_done_q <= 1'b0;
      sw_q       <= 10'h000; // all off: programming port link
    end else if (!cap_done_q) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == 2'h2) begin
        sw_q       <= sw_w; // later switch moves ignored
        cap_done_q <= 1'b1;
      end
    end
  end
  assign slave_addr_out =
    sw_q[`PFIO_SW_ADDR_MSB:`PFIO_SW_ADDR_LSB]; // pos 1 = lsb
  assign conn_fieldbus_out = sw_q[`PFIO_SW_CONN_LO] &
                             sw_q[`PFIO_SW_CONN_HI];
  assign conn_prog_port_out = ~conn_fieldbus_out;
  assign hw_standard_out = ~sw_q[`PFIO_SW_HWVAR_BIT];

  // ----------------------------------------------------------------
  // handwheel counters
  // ----------------------------------------------------------------
  wire [15:0] hw1_w;
  wire [15:0] hw2_w;
  pfio_hw_counter u_hw1 (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .step_in    (step_w[0]),
    .dir_up_in  (dirup_w[0]),
    .present_in (pres_w[0]),
    .count_out  (hw1_w)
  );
  pfio_hw_counter u_hw2 (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .step_in    (step_w[1]),
    .dir_up_in  (dirup_w[1]),
    .present_in (pres_w[1]),
    .count_out  (hw2_w)
  );

  // ----------------------------------------------------------------
  // input image snapshot at each exchange start
  // ----------------------------------------------------------------
  // snapshot keeps one exchange coherent while keys keep moving
  reg [8*`PFIO_IN_BYTES-1:0] img_q;
  reg [4:0]                  in_idx_q;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      img_q    <= {(8*`PFIO_IN_BYTES){1'b0}};
      in_idx_q <= 5'h00;
    end else if (xchg_start_in) begin
      in_idx_q <= 5'h00;
      img_q    <= {rot2_w, rot1_w, 1'b0, cust_w, direct_w[15:8],
                   direct_w[7:0], hw2_w[7:0], hw2_w[15:8],
                   hw1_w[7:0], hw1_w[15:8], keys_w};
      // byte order low..high: std, wheels msb first, extras
    end else if (in_strobe_in &&
                 in_idx_q != `PFIO_IN_BYTES - 1) begin
      in_idx_q <= in_idx_q + 5'h01;
    end
  end
  // byte picker, used for input stream
  function [7:0] pick_byte;
    input [8*`PFIO_IN_BYTES-1:0] img;
    input [4:0]                  idx;
    begin
      pick_byte = img[idx*8 +: 8];
    end
  endfunction
  reg [7:0] in_byte_q;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_byte_q <= 8'h00;
    end else begin
      in_byte_q <= pick_byte(img_q, in_idx_q);
    end
  end
  assign in_byte_out = in_byte_q;

  // ----------------------------------------------------------------
  // output image receive, applied at the next exchange start
  // ----------------------------------------------------------------
  reg  [3:0] out_idx_q;
  reg        apply_q;
  reg  [3:0] rd_idx_q;
  reg        rd_busy_q;
  reg  [3:0] rd_lag_q;
  reg        rd_vld_q;
  wire [7:0] rd_data_w;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_idx_q <= 4'h0;
      apply_q   <= 1'b0;
    end else if (xchg_start_in) begin
      out_idx_q <= 4'h0;
      apply_q   <= (out_idx_q == `PFIO_OUT_BYTES); // full frame only
    end else begin
      apply_q <= 1'b0;
      if (out_strobe_in && out_idx_q != `PFIO_OUT_BYTES) begin
        out_idx_q <= out_idx_q + 4'h1;
      end
    end
  end
  pfio_image_buf #(.DEPTH(`PFIO_OUT_BYTES), .AW(4)) u_obuf (
    .ref_clk_in  (ref_clk_in),
    .wr_en_in    (out_strobe_in && out_idx_q != `PFIO_OUT_BYTES),
    .wr_addr_in  (out_idx_q),
    .wr_data_in  (out_byte_in),
    .rd_addr_in  (rd_idx_q),
    .rd_data_out (rd_data_w)
  );
  // walk the buffer after a complete frame, one byte per cycle
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_idx_q  <= 4'h0;
      rd_busy_q <= 1'b0;
      rd_lag_q  <= 4'h0;
      rd_vld_q  <= 1'b0;
    end else begin
      rd_lag_q <= rd_idx_q;
      rd_vld_q <= rd_busy_q;
      if (apply_q) begin
        rd_busy_q <= 1'b1;
        rd_idx_q  <= 4'h0;
      end else if (rd_busy_q) begin
        if (rd_idx_q == `PFIO_OUT_BYTES - 1) begin
          rd_busy_q <= 1'b0;
        end else begin
          rd_idx_q <= rd_idx_q + 4'h1;
        end
      end
    end
  end
  reg [63:0] std_led_q;
  reg [7:0]  cled_q;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      std_led_q <= 64'h0;
      cled_q    <= 8'h00;
    end else if (rd_vld_q) begin
      if (rd_lag_q < `PFIO_STD_BYTES) begin
        std_led_q[rd_lag_q[2:0]*8 +: 8] <= rd_data_w;
      end else if (rd_lag_q == `PFIO_OUT_CLED) begin
        cled_q <= rd_data_w; // high byte drives leds
      end
      // reserved byte kept zero by the master, ignored here
    end
  end

  // ----------------------------------------------------------------
  // flash divider and front led selection
  // ----------------------------------------------------------------
  reg [31:0] fdiv_q;
  reg        blink_q;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fdiv_q  <= 32'h0;
      blink_q <= 1'b1;
    end else if (fdiv_q == FLASH_CYC - 1) begin
      fdiv_q  <= 32'h0;
      blink_q <= ~blink_q; // one-cycle enable toggles the phase
    end else begin
      fdiv_q <= fdiv_q + 32'h1;
    end
  end
  // thermometer code: n lowest leds of a group lit
  function [LED_GRP-1:0] therm;
    input [3:0] n;
    integer i;
    begin
      therm = {LED_GRP{1'b0}};
      for (i = 0; i < LED_GRP; i = i + 1) begin
        therm[i] = (i < n);
      end
    end
  endfunction
  wire ver_w = fstop_w & fen_w;
  reg [63:0]          led_q;
  reg [7:0]           cled_o_q;
  reg [3*LED_GRP-1:0] ver_q;
  reg                 ver_mode_q;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_q      <= 64'h0;
      cled_o_q   <= 8'h00;
      ver_q      <= {(3*LED_GRP){1'b0}};
      ver_mode_q <= 1'b0;
    end else if (ver_w) begin
      // normal output halted, steady version groups
      led_q      <= 64'h0;
      cled_o_q   <= 8'h00;
      ver_mode_q <= 1'b1;
      ver_q      <= {therm(`PFIO_VER_MAJ), therm(`PFIO_VER_MIN),
                     therm(`PFIO_VER_PATCH)};
    end else if (!cyclic_up_in) begin
      led_q      <= {64{blink_q}}; // all front leds flash
      cled_o_q   <= {8{blink_q}};
      ver_q      <= {(3*LED_GRP){blink_q}};
      ver_mode_q <= 1'b0;
    end else begin
      led_q      <= std_led_q;
      cled_o_q   <= cled_q;
      ver_q      <= {(3*LED_GRP){1'b0}};
      ver_mode_q <= 1'b0;
    end
  end
  assign std_leds_out  = led_q;
  assign cust_leds_out = cled_o_q;
  assign ver_leds_out  = ver_q;
  assign ver_mode_out  = ver_mode_q;
endmodule // pfio_panel

// *** test/pfio_panel_checker.sv ***
// checker for the panel block: led, switch and version relations
// assumes a bind onto pfio_panel; one clock, async active low reset
`timescale 1ns/100ps
`include "pfio_consts.vh"
module pfio_panel_checker #(
  parameter LED_GRP = 8
) (
  input wire                 ref_clk_in,
  input wire                 rst_n_in,
  input wire [9:0]           config_switch_bank_in,
  input wire                 key_feed_stop_in,
  input wire                 key_feed_enable_in,
  input wire                 cyclic_up_in,
  input wire                 xchg_start_in,
  input wire [6:0]           slave_addr_out,
  input wire                 conn_fieldbus_out,
  input wire                 conn_prog_port_out,
  input wire                 hw_standard_out,
  input wire [63:0]          std_leds_out,
  input wire [7:0]           cust_leds_out,
  input wire [3*LED_GRP-1:0] ver_leds_out,
  input wire                 ver_mode_out
);
  reg [2:0] rel_cnt_q;
  reg [4:0] quiet_q;
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  // cycles since release, and cycles with nothing that may move leds
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rel_cnt_q <= 3'h0;
      quiet_q   <= 5'h00;
    end else begin
      if (rel_cnt_q != 3'h7) rel_cnt_q <= rel_cnt_q + 3'h1;
      if (xchg_start_in || !cyclic_up_in || ver_mode_out ||
          key_feed_stop_in || key_feed_enable_in) quiet_q <= 5'h00;
      else if (quiet_q != 5'h1f) quiet_q <= quiet_q + 5'h01;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  flash_all_a: assert property (
    !cyclic_up_in && !$past(cyclic_up_in, 4) && !ver_mode_out &&
    !$past(ver_mode_out, 2) |-> (&std_leds_out || ~|std_leds_out) &&
    (&cust_leds_out || ~|cust_leds_out))
    else $error("leds not all alike while flashing");
  ver_enter_a: assert property (
    (key_feed_stop_in && key_feed_enable_in) [*5] |-> ver_mode_out)
    else $error("version display not entered");
  ver_groups_a: assert property (
    ver_mode_out && $past(ver_mode_out) |->
    $countones(ver_leds_out[3*LED_GRP-1:2*LED_GRP]) == `PFIO_VER_MAJ &&
    $countones(ver_leds_out[2*LED_GRP-1:LED_GRP]) == `PFIO_VER_MIN &&
    $countones(ver_leds_out[LED_GRP-1:0]) == `PFIO_VER_PATCH)
    else $error("version group counts wrong");
  ver_steady_a: assert property (ver_mode_out [*3] |->
    $stable(ver_leds_out)) else $error("version leds not steady");
  sw_hold_a: assert property (
    rel_cnt_q >= 3'h5 |-> $stable(slave_addr_out) &&
    $stable(conn_fieldbus_out) && $stable(hw_standard_out))
    else $error("switch outputs moved after capture");
  conn_excl_a: assert property (
    conn_fieldbus_out != conn_prog_port_out)
    else $error("connection type not exclusive");
  sw_decode_a: assert property (rel_cnt_q == 3'h5 &&
    config_switch_bank_in == $past(config_switch_bank_in, 5) |->
    slave_addr_out == config_switch_bank_in[6:0] &&
    conn_fieldbus_out == (config_switch_bank_in[9] & config_switch_bank_in[8])
    && hw_standard_out == !config_switch_bank_in[7])
    else $error("switch decode wrong");
  led_quiet_a: assert property (
    quiet_q == 5'h1f |-> $stable(std_leds_out) && $stable(cust_leds_out))
    else $error("leds moved without exchange");
endmodule // pfio_panel_checker

// *** test/pfio_master_model.sv ***
// fieldbus master engine model: one cyclic exchange per frame call
// assumes the panel takes strobes at rising edges; drives at falling
`timescale 1ns/100ps
`include "pfio_consts.vh"
module pfio_master_model (
  input  wire       ref_clk_in,
  input  wire [7:0] in_byte_in,
  output reg        xchg_start_out,
  output reg        out_strobe_out,
  output reg        in_strobe_out,
  output reg  [7:0] out_byte_out
);
  initial begin
    xchg_start_out = 1'b0;
    out_strobe_out = 1'b0;
    in_strobe_out  = 1'b0;
    out_byte_out   = 8'h00;
  end
  // start, n output bytes back to back, then walk all 17 input bytes
  task frame(input [79:0] oimg, input integer nout, output [135:0] iimg);
    integer i;
    begin
      @(negedge ref_clk_in) xchg_start_out = 1'b1;
      @(negedge ref_clk_in) xchg_start_out = 1'b0;
      for (i = 0; i < nout; i = i + 1) begin
        out_strobe_out = 1'b1;
        out_byte_out   = oimg[8*i +: 8];
        @(negedge ref_clk_in);
      end
      out_strobe_out = 1'b0;
      // released data shows garbage, not the last byte
      out_byte_out = ~out_byte_out;
      repeat (3) @(negedge ref_clk_in);
      for (i = 0; i < `PFIO_IN_BYTES; i = i + 1) begin
        iimg[8*i +: 8] = in_byte_in;
        in_strobe_out  = 1'b1;
        @(negedge ref_clk_in) in_strobe_out = 1'b0;
        repeat (2) @(negedge ref_clk_in);
      end
    end
  endtask
endmodule // pfio_master_model

// *** test/pfio_panel_bench.sv ***
// self-checking bench for pfio_panel with a fieldbus master model
// assumes the checker and master model files are compiled first
`timescale 1ns/100ps
`include "pfio_consts.vh"
module pfio_panel_bench;
  reg          clk, rst_n, stop_key, en_key, cyc_up;
  reg  [9:0]   sw;
  reg  [63:0]  std_keys;
  reg  [1:0]   hw_step, hw_dir, hw_pres;
  reg  [15:0]  direct;
  reg  [6:0]   cust;
  reg  [7:0]   rot1, rot2;
  reg  [15:0]  w_exp [0:1];
  reg  [135:0] img_seen;
  reg  [23:0]  v0;
  reg          seen_on, seen_off;
  wire         xchg, ostb, istb, fb, prog, hwstd, vmode;
  wire [7:0]   obyte, ibyte, cleds;
  wire [6:0]   addr;
  wire [63:0]  sleds;
  wire [23:0]  vleds;
  integer      bad_count, compares, i;
  // ----------------------------------------------------------------
  // instances and clock
  // ----------------------------------------------------------------
  // short flash period keeps the run brief
  pfio_panel #(.FLASH_CYC(4), .LED_GRP(8)) u_pfio_panel (
    .ref_clk_in(clk), .rst_n_in(rst_n), .config_switch_bank_in(sw),
    .std_keys_in(std_keys), .key_feed_stop_in(stop_key),
    .key_feed_enable_in(en_key), .hw_step_in(hw_step),
    .hw_dir_up_in(hw_dir), .hw_present_in(hw_pres), .direct_keys_in(direct),
    .cust_keys_in(cust), .rotary1_in(rot1), .rotary2_in(rot2),
    .cyclic_up_in(cyc_up), .xchg_start_in(xchg), .out_strobe_in(ostb),
    .out_byte_in(obyte), .in_strobe_in(istb), .in_byte_out(ibyte),
    .slave_addr_out(addr), .conn_fieldbus_out(fb),
    .conn_prog_port_out(prog), .hw_standard_out(hwstd),
    .std_leds_out(sleds), .cust_leds_out(cleds), .ver_leds_out(vleds),
    .ver_mode_out(vmode));
  pfio_master_model u_pfio_master_model (.ref_clk_in(clk),
    .in_byte_in(ibyte), .xchg_start_out(xchg), .out_strobe_out(ostb),
    .in_strobe_out(istb), .out_byte_out(obyte));
  always #2 clk = ~clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input [8*10-1:0] what, input [135:0] exp, input [135:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // switch sampled only once after reset release, so each setting needs one
  task do_reset(input [9:0] s);
    begin
      sw = s;
      rst_n = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      check("addr", s[6:0], addr);
      check("conn", {s[9] & s[8], ~(s[9] & s[8])}, {fb, prog});
      // logical not keeps the expectation one bit wide
      check("hwvar", !s[7], hwstd);
    end
  endtask
  // one exchange; absent wheels must read zero in the image
  task xchg_check(input [79:0] o, input integer n);
    begin
      u_pfio_master_model.frame(o, n, img_seen);
      check("in_image", {rot2, rot1, 1'b0, cust, direct,
        hw_pres[1] ? {w_exp[1][7:0], w_exp[1][15:8]} : 16'h0000,
        hw_pres[0] ? {w_exp[0][7:0], w_exp[0][15:8]} : 16'h0000,
        std_keys}, img_seen);
    end
  endtask
  task wheel(input integer w, input up, input integer n);
    begin
      hw_dir[w] = up;
      // counter adds one per sampled-high cycle, so pulse one cycle
      repeat (n) begin
        hw_step[w] = 1'b1;
        @(negedge clk);
        hw_step[w] = 1'b0;
        repeat (3) @(negedge clk);
        w_exp[w] = up ? w_exp[w] + 16'h0001 : w_exp[w] - 16'h0001;
      end
    end
  endtask
  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rst_n = 1'b0; sw = 10'h000; stop_key = 1'b0;
    en_key = 1'b0; cyc_up = 1'b0; hw_step = 2'h0; hw_dir = 2'h0;
    hw_pres = 2'h3; std_keys = 64'h0123_4567_89ab_cdef;
    direct = 16'hbeef; cust = 7'h55; rot1 = 8'h3c; rot2 = 8'hc3;
    bad_count = 0; compares = 0; seen_on = 1'b0; seen_off = 1'b0;
    w_exp[0] = 16'h0000; w_exp[1] = 16'h0000;
    do_reset(10'h000); do_reset(10'h07e); do_reset(10'h3ff);
    do_reset(10'h305);
    sw = 10'h2aa;
    repeat (6) @(negedge clk);
    check("addr_hold", 7'h05, addr);
    for (i = 0; i < 16; i = i + 1) begin
      @(negedge clk);
      check("flash", 1'b1, (&sleds || ~|sleds) && (&cleds || ~|cleds));
      seen_on = seen_on | (&sleds);
      seen_off = seen_off | (~|sleds);
    end
    check("flash_both", 2'h3, {seen_on, seen_off});
    stop_key = 1'b1; en_key = 1'b1;
    repeat (6) @(negedge clk);
    v0 = vleds;
    for (i = 0; i < 12; i = i + 1) begin
      @(negedge clk);
      check("ver_mode", {1'b1, v0}, {vmode, vleds});
    end
    check("ver_cnt", {32'd1, 32'd2, 32'd0}, {$countones(vleds[23:16]),
      $countones(vleds[15:8]), $countones(vleds[7:0])});
    stop_key = 1'b0; en_key = 1'b0; cyc_up = 1'b1;
    repeat (8) @(negedge clk);
    xchg_check(80'h0, 0);
    wheel(0, 1'b1, 260);
    wheel(1, 1'b0, 3);
    xchg_check(80'h0, 0);
    hw_pres[1] = 1'b0;
    repeat (4) @(negedge clk);
    xchg_check(80'h0, 0);
    xchg_check({8'ha5, 8'h00, 64'hfedc_ba98_7654_3210}, 10);
    xchg_check(80'h0, 0);
    repeat (20) @(negedge clk);
    check("leds", {8'ha5, 64'hfedc_ba98_7654_3210}, {cleds, sleds});
    xchg_check({8'h3c, 8'h00, 64'h1111_2222_3333_4444}, 9);
    xchg_check(80'h0, 0);
    repeat (20) @(negedge clk);
    check("leds_short", {8'ha5, 64'hfedc_ba98_7654_3210}, {cleds, sleds});
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count = bad_count + 1;
    finish_test;
  end
endmodule // pfio_panel_bench
bind pfio_panel pfio_panel_checker #(.LED_GRP(LED_GRP)) u_pfio_panel_checker (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .config_switch_bank_in(config_switch_bank_in),
  .key_feed_stop_in(key_feed_stop_in), .key_feed_enable_in(key_feed_enable_in),
  .cyclic_up_in(cyclic_up_in), .xchg_start_in(xchg_start_in),
  .slave_addr_out(slave_addr_out), .conn_fieldbus_out(conn_fieldbus_out),
  .conn_prog_port_out(conn_prog_port_out), .hw_standard_out(hw_standard_out),
  .std_leds_out(std_leds_out), .cust_leds_out(cust_leds_out),
  .ver_leds_out(ver_leds_out), .ver_mode_out(ver_mode_out));
